// *** inc/pm_timer_pkg.sv ***
// Constants and carriers for the 8-bit period-match timer.
// Assumes a simple strobe register port and one 100 MHz clock.
package pm_timer_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [2:0] ADDR_TIMER_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_PERIOD_COUNT = 3'h1;
	localparam logic [2:0] ADDR_PERIOD_LIMIT = 3'h2;
	localparam logic [2:0] ADDR_INT_FLAGS = 3'h3;
	localparam logic [2:0] ADDR_INT_ENABLE = 3'h4;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CTL_IN_DIV_LSB = 0;
	localparam int CTL_RUN_BIT = 2;
	localparam int CTL_MATCH_DIV_LSB = 3;
	localparam int FLAG_MATCH_BIT = 1;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;
	localparam logic [7:0] FLAGS_WRITE_MASK = 8'h7f;
	localparam logic [7:0] ENABLE_WRITE_MASK = 8'h7f;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RESET_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] RESET_PERIOD_COUNT = 8'h00;
	localparam logic [7:0] RESET_PERIOD_LIMIT = 8'hff;
	localparam logic [7:0] RESET_INT_FLAGS = 8'h00;
	localparam logic [7:0] RESET_INT_ENABLE = 8'h00;
	// ---------------------------------------------------------------
	// Timing counts
	// ---------------------------------------------------------------
	localparam int INSTR_CLK_DIV = 4;
	localparam logic [3:0] PRESCALE_1 = 4'h0;
	localparam logic [3:0] PRESCALE_4 = 4'h3;
	localparam logic [3:0] PRESCALE_16 = 4'hf;
	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic [3:0] match_div;
		logic run;
		logic [1:0] in_div;
	} ctl_fields_t;
endpackage : pm_timer_pkg

// *** design/pm_prescaler.sv ***
// Instruction clock divider followed by the selectable input prescaler.
// Assumes i_clear is a one-cycle pulse from the register logic.
`timescale 1ns/1ps
module pm_prescaler (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic [1:0] i_sel,
	output logic o_tick
);
	logic [1:0] phase_r, phase_nxt;
	logic [3:0] pre_r, pre_nxt;
	logic tick_nxt;
	logic [3:0] limit;

	function automatic logic [3:0] pre_limit(input logic [1:0] sel);
		if (sel[1]) begin
			pre_limit = pm_timer_pkg::PRESCALE_16;
		end else if (sel[0]) begin
			pre_limit = pm_timer_pkg::PRESCALE_4;
		end else begin
			pre_limit = pm_timer_pkg::PRESCALE_1;
		end
	endfunction : pre_limit

	always_comb begin
		limit = pre_limit(i_sel);
		phase_nxt = phase_r;
		pre_nxt = pre_r;
		tick_nxt = 1'b0;
		if (i_clear) begin
			phase_nxt = 2'h0;
			pre_nxt = 4'h0;
		end else if (i_run) begin
			phase_nxt = phase_r + 2'h1;
			if (phase_r == 2'(pm_timer_pkg::INSTR_CLK_DIV - 1)) begin
				if (pre_r >= limit) begin
					pre_nxt = 4'h0;
					tick_nxt = 1'b1;
				end else begin
					pre_nxt = pre_r + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			phase_r <= 2'h0;
			pre_r <= 4'h0;
			o_tick <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			pre_r <= pre_nxt;
			o_tick <= tick_nxt;
		end
	end

	property p_stop_hold;
		@(posedge i_clk) disable iff (i_reset)
		(!i_run && !i_clear) |=> (phase_r == $past(phase_r) && pre_r == $past(pre_r));
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("prescaler moved while stopped");
	property p_clear;
		@(posedge i_clk) disable iff (i_reset)
		i_clear |=> (phase_r == 2'h0 && pre_r == 4'h0);
	endproperty
	a_clear: assert property (p_clear) else $error("prescaler not cleared");
endmodule : pm_prescaler

// *** design/pm_postscaler.sv ***
// Match postscaler: emits one pulse per (select plus one) matches.
// Assumes i_match is a one-cycle pulse.
`timescale 1ns/1ps
module pm_postscaler (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clear,
	input wire logic i_match,
	input wire logic [3:0] i_sel,
	output logic o_event
);
	logic [3:0] post_r, post_nxt;
	logic event_nxt;

	always_comb begin
		post_nxt = post_r;
		event_nxt = 1'b0;
		if (i_clear) begin
			post_nxt = 4'h0;
		end else if (i_match) begin
			if (post_r >= i_sel) begin
				post_nxt = 4'h0;
				event_nxt = 1'b1;
			end else begin
				post_nxt = post_r + 4'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			post_r <= 4'h0;
			o_event <= 1'b0;
		end else begin
			post_r <= post_nxt;
			o_event <= event_nxt;
		end
	end

	property p_ratio1;
		@(posedge i_clk) disable iff (i_reset)
		(i_match && !i_clear && i_sel == 4'h0) |=> o_event;
	endproperty
	a_ratio1: assert property (p_ratio1) else $error("1:1 postscale missed");
	property p_no_event;
		@(posedge i_clk) disable iff (i_reset)
		!i_match |=> !o_event;
	endproperty
	a_no_event: assert property (p_no_event) else $error("event without match");
endmodule : pm_postscaler

// *** design/period_match_timer_8bit.sv ***
// Top of the 8-bit period-match timer with its register port.
// Assumes a strobe register master with read data one cycle later.
`timescale 1ns/1ps
module period_match_timer_8bit (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_match_flag,
	output logic [7:0] o_count
);
	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	pm_timer_pkg::reg_req_t req;
	pm_timer_pkg::ctl_fields_t ctl;
	logic [7:0] control_r, control_nxt;
	logic [7:0] count_r, count_nxt;
	logic [7:0] limit_r, limit_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [7:0] enable_r, enable_nxt;
	logic [7:0] rdata_nxt;
	logic tick;
	logic post_event;
	logic match_pulse;
	logic div_clear;
	logic wr_count;
	logic wr_ctl;

	// ---------------------------------------------------------------
	// Decoding
	// ---------------------------------------------------------------
	function automatic logic wr_hit(input pm_timer_pkg::reg_req_t r, input logic [2:0] a);
		wr_hit = r.wr && r.addr == a;
	endfunction : wr_hit

	function automatic logic rd_hit(input pm_timer_pkg::reg_req_t r, input logic [2:0] a);
		rd_hit = r.rd && r.addr == a;
	endfunction : rd_hit

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign ctl = control_r[6:0];
	assign wr_count = wr_hit(req, pm_timer_pkg::ADDR_PERIOD_COUNT);
	assign wr_ctl = wr_hit(req, pm_timer_pkg::ADDR_TIMER_CONTROL);
	assign div_clear = wr_count || wr_ctl;
	assign match_pulse = tick && ctl.run && count_r == limit_r && !wr_count;

	// ---------------------------------------------------------------
	// Dividers
	// ---------------------------------------------------------------
	pm_prescaler pm_prescaler_i (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_clear(div_clear),
		.i_run(ctl.run),
		.i_sel(ctl.in_div),
		.o_tick(tick)
	);

	pm_postscaler pm_postscaler_i (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_clear(div_clear),
		.i_match(match_pulse),
		.i_sel(ctl.match_div),
		.o_event(post_event)
	);

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		control_nxt = control_r;
		count_nxt = count_r;
		limit_nxt = limit_r;
		flags_nxt = flags_r;
		enable_nxt = enable_r;
		rdata_nxt = 8'h00;
		if (tick && ctl.run) begin
			if (count_r == limit_r) begin
				count_nxt = 8'h00;
			end else begin
				count_nxt = count_r + 8'h01;
			end
		end
		if (req.wr) begin
			case (req.addr)
				pm_timer_pkg::ADDR_TIMER_CONTROL: begin
					control_nxt = req.wdata & pm_timer_pkg::CTL_WRITE_MASK;
				end
				pm_timer_pkg::ADDR_PERIOD_COUNT: begin
					count_nxt = req.wdata;
				end
				pm_timer_pkg::ADDR_PERIOD_LIMIT: begin
					limit_nxt = req.wdata;
				end
				pm_timer_pkg::ADDR_INT_FLAGS: begin
					flags_nxt = req.wdata & pm_timer_pkg::FLAGS_WRITE_MASK;
				end
				pm_timer_pkg::ADDR_INT_ENABLE: begin
					enable_nxt = req.wdata & pm_timer_pkg::ENABLE_WRITE_MASK;
				end
				default: begin
				end
			endcase
		end
		if (post_event) begin
			flags_nxt[pm_timer_pkg::FLAG_MATCH_BIT] = 1'b1;
		end
		if (req.rd) begin
			case (req.addr)
				pm_timer_pkg::ADDR_TIMER_CONTROL: rdata_nxt = control_r;
				pm_timer_pkg::ADDR_PERIOD_COUNT: rdata_nxt = count_r;
				pm_timer_pkg::ADDR_PERIOD_LIMIT: rdata_nxt = limit_r;
				pm_timer_pkg::ADDR_INT_FLAGS: rdata_nxt = flags_r;
				pm_timer_pkg::ADDR_INT_ENABLE: rdata_nxt = enable_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			control_r <= pm_timer_pkg::RESET_TIMER_CONTROL;
			count_r <= pm_timer_pkg::RESET_PERIOD_COUNT;
			limit_r <= pm_timer_pkg::RESET_PERIOD_LIMIT;
			flags_r <= pm_timer_pkg::RESET_INT_FLAGS;
			enable_r <= pm_timer_pkg::RESET_INT_ENABLE;
			o_rdata <= 8'h00;
			o_match_flag <= 1'b0;
			o_count <= pm_timer_pkg::RESET_PERIOD_COUNT;
		end else begin
			control_r <= control_nxt;
			count_r <= count_nxt;
			limit_r <= limit_nxt;
			flags_r <= flags_nxt;
			enable_r <= enable_nxt;
			o_rdata <= rdata_nxt;
			o_match_flag <= flags_nxt[pm_timer_pkg::FLAG_MATCH_BIT];
			o_count <= count_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_bit7_zero;
		@(posedge i_clk) disable iff (i_reset)
		control_r[7] == 1'b0;
	endproperty
	a_bit7_zero: assert property (p_bit7_zero) else $error("control bit 7 set");
	property p_ctl_keeps_count;
		@(posedge i_clk) disable iff (i_reset)
		(wr_ctl && !(tick && ctl.run)) |=> count_r == $past(count_r);
	endproperty
	a_ctl_keeps_count: assert property (p_ctl_keeps_count) else $error("count changed");
	property p_stop_hold;
		@(posedge i_clk) disable iff (i_reset)
		(!ctl.run && !wr_count) |=> count_r == $past(count_r);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("count moved while stopped");
	property p_wrap;
		@(posedge i_clk) disable iff (i_reset)
		(tick && ctl.run && count_r == limit_r && !wr_count) |=> count_r == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap");
	property p_step;
		@(posedge i_clk) disable iff (i_reset)
		(tick && ctl.run && count_r != limit_r && !wr_count) |=> count_r == $past(count_r) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count did not step");
	property p_flag_sticky;
		@(posedge i_clk) disable iff (i_reset)
		(o_match_flag && !(req.wr && req.addr == pm_timer_pkg::ADDR_INT_FLAGS)) |=> o_match_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
	property p_event_sets;
		@(posedge i_clk) disable iff (i_reset)
		post_event |=> o_match_flag;
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("flag not set");
	property p_read_count;
		@(posedge i_clk) disable iff (i_reset)
		(req.rd && req.addr == pm_timer_pkg::ADDR_PERIOD_COUNT) |=> o_rdata == $past(count_r);
	endproperty
	a_read_count: assert property (p_read_count) else $error("bad count read");
	property p_count_idle;
		@(posedge i_clk) disable iff (i_reset)
		(!(tick && ctl.run) && !wr_count) |=> count_r == $past(count_r);
	endproperty
	a_count_idle: assert property (p_count_idle) else $error("count moved without tick");
	property p_match_post;
		@(posedge i_clk) disable iff (i_reset)
		(match_pulse && !div_clear && ctl.match_div == 4'h0) |=> post_event;
	endproperty
	a_match_post: assert property (p_match_post) else $error("match lost at 1:1");
	property p_post_needs_match;
		@(posedge i_clk) disable iff (i_reset)
		post_event |-> $past(match_pulse);
	endproperty
	a_post_needs_match: assert property (p_post_needs_match) else $error("stray event");
	property p_no_match_stopped;
		@(posedge i_clk) disable iff (i_reset)
		!ctl.run |=> !post_event;
	endproperty
	a_no_match_stopped: assert property (p_no_match_stopped) else $error("event while off");
	property p_tick_stopped;
		@(posedge i_clk) disable iff (i_reset)
		(!ctl.run && !div_clear) |=> !tick;
	endproperty
	a_tick_stopped: assert property (p_tick_stopped) else $error("tick while off");
	property p_clear_tick;
		@(posedge i_clk) disable iff (i_reset)
		div_clear |=> !tick;
	endproperty
	a_clear_tick: assert property (p_clear_tick) else $error("tick after divider clear");
	property p_flag_clear;
		@(posedge i_clk) disable iff (i_reset)
		(wr_hit(req, pm_timer_pkg::ADDR_INT_FLAGS) && !i_wdata[pm_timer_pkg::FLAG_MATCH_BIT]
			&& !post_event) |=> !o_match_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	// ---------------------------------------------------------------
	// Register port checks
	// ---------------------------------------------------------------
	property p_count_write;
		@(posedge i_clk) disable iff (i_reset)
		wr_count |=> count_r == $past(i_wdata);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");
	property p_limit_write;
		@(posedge i_clk) disable iff (i_reset)
		wr_hit(req, pm_timer_pkg::ADDR_PERIOD_LIMIT) |=> limit_r == $past(i_wdata);
	endproperty
	a_limit_write: assert property (p_limit_write) else $error("limit write lost");
	property p_limit_hold;
		@(posedge i_clk) disable iff (i_reset)
		!wr_hit(req, pm_timer_pkg::ADDR_PERIOD_LIMIT) |=> limit_r == $past(limit_r);
	endproperty
	a_limit_hold: assert property (p_limit_hold) else $error("limit changed");
	property p_ctl_write;
		@(posedge i_clk) disable iff (i_reset)
		wr_ctl |=> control_r == ($past(i_wdata) & pm_timer_pkg::CTL_WRITE_MASK);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("control write wrong");
	property p_enable_write;
		@(posedge i_clk) disable iff (i_reset)
		wr_hit(req, pm_timer_pkg::ADDR_INT_ENABLE)
			|=> enable_r == ($past(i_wdata) & pm_timer_pkg::ENABLE_WRITE_MASK);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write wrong");
	property p_read_limit;
		@(posedge i_clk) disable iff (i_reset)
		rd_hit(req, pm_timer_pkg::ADDR_PERIOD_LIMIT) |=> o_rdata == $past(limit_r);
	endproperty
	a_read_limit: assert property (p_read_limit) else $error("bad limit read");
	property p_read_ctl;
		@(posedge i_clk) disable iff (i_reset)
		rd_hit(req, pm_timer_pkg::ADDR_TIMER_CONTROL) |=> o_rdata == $past(control_r) && !o_rdata[7];
	endproperty
	a_read_ctl: assert property (p_read_ctl) else $error("bad control read");
	property p_read_flags;
		@(posedge i_clk) disable iff (i_reset)
		rd_hit(req, pm_timer_pkg::ADDR_INT_FLAGS) |=> o_rdata == $past(flags_r);
	endproperty
	a_read_flags: assert property (p_read_flags) else $error("bad flags read");
	property p_read_enable;
		@(posedge i_clk) disable iff (i_reset)
		rd_hit(req, pm_timer_pkg::ADDR_INT_ENABLE) |=> o_rdata == $past(enable_r);
	endproperty
	a_read_enable: assert property (p_read_enable) else $error("bad enable read");
	property p_rdata_idle;
		@(posedge i_clk) disable iff (i_reset)
		!req.rd |=> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	// ---------------------------------------------------------------
	// Coverage
	// ---------------------------------------------------------------
	c_match: cover property (@(posedge i_clk) disable iff (i_reset) match_pulse);
	c_event: cover property (@(posedge i_clk) disable iff (i_reset) post_event);
	c_ctl_write: cover property (@(posedge i_clk) disable iff (i_reset) wr_ctl && ctl.run);
	c_flag_clear: cover property (@(posedge i_clk) disable iff (i_reset)
		wr_hit(req, pm_timer_pkg::ADDR_INT_FLAGS) && o_match_flag);
	c_stopped_equal: cover property (@(posedge i_clk) disable iff (i_reset)
		!ctl.run && count_r == limit_r);
endmodule : period_match_timer_8bit

// *** tb/testbench.sv ***
// Self-checking bench for the 8-bit period-match timer.
// Assumes the design package and the top module compiled before this file.
`timescale 1ns/1ps
module testbench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic o_match_flag;
	logic [7:0] o_count;
	int n_mismatch = 0;
	int checked = 0;
	int cyc = 0;

	period_match_timer_8bit period_match_timer_8bit_i (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.o_match_flag(o_match_flag),
		.o_count(o_count)
	);

	always #5 i_clk = ~i_clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd

	task automatic wait_step(output int dt);
		logic [7:0] old;
		old = o_count;
		dt = 0;
		while (o_count === old && dt < 300) begin
			@(posedge i_clk);
			#1;
			dt++;
		end
	endtask : wait_step

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_reset_regs;
		rd(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rd(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'h00);
		rd(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'hff);
		rd(pm_timer_pkg::ADDR_INT_FLAGS, 8'h00);
		rd(pm_timer_pkg::ADDR_INT_ENABLE, 8'h00);
		wr(3'h5, 8'h5a);
		rd(3'h5, 8'h00);
		wr(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'ha5);
		rd(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'ha5);
		wr(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'h3c);
		rd(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'h3c);
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h80);
		rd(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		$display("Register reset and access test done");
	endtask : test_reset_regs

	task automatic test_prescale;
		int dt;
		int exp;
		for (int s = 0; s < 4; s++) begin
			exp = (s == 0) ? 4 : (s == 1) ? 16 : 64;
			wr(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'hff);
			wr(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'h00);
			wr(pm_timer_pkg::ADDR_TIMER_CONTROL, {5'h00, 1'b1, s[1:0]});
			wait_step(dt);
			chk(8'(dt), 8'(exp + 1));
			wait_step(dt);
			chk(8'(dt), 8'(exp));
		end
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		$display("Prescale test done");
	endtask : test_prescale

	task automatic test_match(input logic [3:0] ps);
		int dt;
		int nm;
		logic [7:0] old;
		wr(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'h02);
		wr(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'h00);
		wr(pm_timer_pkg::ADDR_INT_FLAGS, 8'h00);
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, {1'b0, ps, 3'h4});
		nm = 0;
		old = o_count;
		while (1) begin
			wait_step(dt);
			chk(o_count, (old == 8'h02) ? 8'h00 : old + 8'h01);
			@(posedge i_clk);
			#1;
			chk({7'h00, o_match_flag}, {7'h00, nm > ps});
			if (nm > ps) begin
				break;
			end
			if (o_count == 8'h02) begin
				nm++;
			end
			old = o_count;
		end
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rd(pm_timer_pkg::ADDR_INT_FLAGS, 8'h02);
		wr(pm_timer_pkg::ADDR_INT_FLAGS, 8'h00);
		rd(pm_timer_pkg::ADDR_INT_FLAGS, 8'h00);
		$display("Match and postscale test done, select %0d", ps);
	endtask : test_match

	task automatic test_stopped;
		wr(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'h05);
		wr(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'h05);
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h06);
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h7b);
		#1;
		chk(o_count, 8'h05);
		rd(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h7b);
		repeat (100) @(posedge i_clk);
		#1;
		chk(o_count, 8'h05);
		chk({7'h00, o_match_flag}, 8'h00);
		$display("Stopped timer test done");
	endtask : test_stopped

	task automatic test_mid_reset;
		wr(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'h3c);
		wr(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'h12);
		wr(pm_timer_pkg::ADDR_INT_FLAGS, 8'h02);
		wr(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h04);
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		chk(o_count, 8'h00);
		chk({7'h00, o_match_flag}, 8'h00);
		rd(pm_timer_pkg::ADDR_PERIOD_LIMIT, 8'hff);
		rd(pm_timer_pkg::ADDR_TIMER_CONTROL, 8'h00);
		rd(pm_timer_pkg::ADDR_PERIOD_COUNT, 8'h00);
		$display("Mid-run reset test done");
	endtask : test_mid_reset

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		test_reset_regs();
		test_prescale();
		test_match(4'h0);
		test_match(4'h1);
		test_match(4'hf);
		test_stopped();
		test_mid_reset();
		stop_test();
	end
endmodule : testbench
